//--- rtl/lim_defines.svh
`ifndef LIM_DEFINES_SVH
`define LIM_DEFINES_SVH

// Register indices; byte address is four times the index
`define LIM_NUM_REGS 16
`define LIM_IDX_INDEX 4'h0
`define LIM_IDX_DATA 4'h1
`define LIM_IDX_CHAN_FIRST 4'h2
`define LIM_IDX_CHAN_LAST 4'h9
`define LIM_IDX_CAL 4'hA
`define LIM_IDX_FWREV 4'hB
`define LIM_IDX_FAULT 4'hC
`define LIM_IDX_CFG 4'hD
`define LIM_IDX_COMM 4'hE
`define LIM_IDX_ID 4'hF

// Byte address layout
`define LIM_ADDR_IDX_LSB 2
`define LIM_ADDR_IDX_MSB 5
`define LIM_ADDR_MAP_LSB 6

// Configuration and status bit positions
`define LIM_CFG_CONFIGURED 0
`define LIM_CFG_FORCE_ERR 1
`define LIM_CFG_MAINS_50HZ 2
`define LIM_CFG_SELF_CAL 3
`define LIM_CFG_DIAG 7
`define LIM_CFG_WMASK 16'h008F
`define LIM_STS_MEM_ERR 8
`define LIM_STS_REF_A 9
`define LIM_STS_REF_B 10
`define LIM_STS_NOT_CAL 11
`define LIM_STS_FIELD_PWR 14
`define LIM_STS_POINT_FAULT 15
`define LIM_COMM_PRESENT_LSB 8

// Reset values
`define LIM_CFG_RESET 16'h0000
`define LIM_CAL_RESET 16'h0000
`define LIM_INDEX_RESET 16'h0000
`define LIM_RDATA_RESET 32'h0000_0000
`define LIM_CTRL_RESET 5'h00

`endif

//--- rtl/lim_pkg.sv
package lim_pkg;

    typedef struct packed {
        logic [15:0] value;
        logic comm_fail;
        logic range_fault;
        logic fuse_blown;
        logic open_loop;
        logic ref_error;
    } lim_chan_in_t;

    typedef struct packed {
        logic mem_error;
        logic ref_err_a;
        logic ref_err_b;
        logic not_calibrated;
        logic field_power_fail;
    } lim_diag_in_t;

    typedef struct packed {
        logic configured;
        logic error_led;
        logic mains_50hz;
        logic self_cal;
        logic diag;
    } lim_ctrl_out_t;

    typedef enum logic [1:0] {
        LIM_DP_IDLE,
        LIM_DP_WRITE,
        LIM_DP_READ1,
        LIM_DP_READ2
    } lim_dphase_t;

endpackage

//--- rtl/lim_regs.sv
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "lim_defines.svh"
// Notes on behaviour
// - Sixteen word registers, own read/write meanings
// - Registers 2-9 read channel values, ignore writes
// - Register 10 factory calibration, read and write
// - Register 12 reads fault flags, writes ignored
// - Register 13 writes config, reads status
// - Register 15 reads identity, writes ignored
// - Fault bit 0: channel one link failed
// - Fault bit 1: channel one range/fuse/open loop
// - Fault bit 2: channel two link failed
// - Fault bit 3: channel two out of range
// - Even bits 4-14: channel 3-8 reference error
// - Odd bits 5-15: channel 3-8 out of range
// - Config bit 0 sets, status bit 0 reports
// - Config bit 1 forces error and indicator
module lim_regs
    import lim_pkg::*;
#(
    parameter int NUM_CHAN = 8,
    parameter int MEM_DEPTH = 256,
    // Arbitrary value
    parameter logic [15:0] FW_REVISION = 16'h0001,
    // Arbitrary value
    parameter logic [15:0] ELECTRONIC_ID = 16'h5A5A
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire lim_chan_in_t chan_in [NUM_CHAN],
    input wire lim_diag_in_t diag_in,
    input wire logic [7:0] field_dev_present,
    output lim_ctrl_out_t ctrl_out
);

    localparam int MEM_AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    // Data-phase tracking
    lim_dphase_t dphase;
    lim_dphase_t next_dphase;
    logic [3:0] addr_idx;
    logic addr_mapped;

    // Software-visible storage
    logic [15:0] indirect_index;
    logic [15:0] factory_calibration;
    logic [15:0] module_config;
    logic [15:0] indirect_mem [MEM_DEPTH];

    // Address-phase decode
    wire addr_phase_ok;
    wire addr_in_window;
    wire [3:0] haddr_idx;

    assign addr_phase_ok = hsel & htrans[1] & hready;
    assign addr_in_window = (haddr[31:`LIM_ADDR_MAP_LSB] == '0);
    assign haddr_idx = haddr[`LIM_ADDR_IDX_MSB:`LIM_ADDR_IDX_LSB];

    // Reads take one wait state so that a read right after a write
    // always sees the value that write stored.
    assign hreadyout = (dphase != LIM_DP_READ1);
    assign hresp = 1'b0;

    always_comb begin
        next_dphase = dphase;
        unique case (dphase)
            LIM_DP_READ1: begin
                next_dphase = LIM_DP_READ2;
            end
            LIM_DP_IDLE,
            LIM_DP_WRITE,
            LIM_DP_READ2: begin
                if (addr_phase_ok) begin
                    next_dphase = hwrite ? LIM_DP_WRITE : LIM_DP_READ1;
                end else begin
                    next_dphase = LIM_DP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= LIM_DP_IDLE;
        end else if (clk_en) begin
            dphase <= next_dphase;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_idx <= 4'h0;
            addr_mapped <= 1'b0;
        end else if (clk_en && addr_phase_ok && hreadyout) begin
            addr_idx <= haddr_idx;
            addr_mapped <= addr_in_window;
        end
    end

    // Write decode in the data phase, where hwdata is valid
    wire wr_ok;
    wire wr_index;
    wire wr_data;
    wire wr_cal;
    wire wr_cfg;
    wire [15:0] wr_word;

    assign wr_ok = clk_en & (dphase == LIM_DP_WRITE) & addr_mapped;
    assign wr_word = hwdata[15:0];
    assign wr_index = wr_ok & (addr_idx == `LIM_IDX_INDEX);
    assign wr_data = wr_ok & (addr_idx == `LIM_IDX_DATA);
    assign wr_cal = wr_ok & (addr_idx == `LIM_IDX_CAL);
    assign wr_cfg = wr_ok & (addr_idx == `LIM_IDX_CFG);

    // Indirect window; indices past the array are dropped on write
    // and read as zero, so MEM_DEPTH must not exceed 65536.
    wire idx_in_range;
    wire [MEM_AW-1:0] mem_addr;
    wire [15:0] mem_rdata;

    assign idx_in_range = ({16'h0000, indirect_index} < 32'(MEM_DEPTH));
    assign mem_addr = indirect_index[MEM_AW-1:0];
    assign mem_rdata = idx_in_range ? indirect_mem[mem_addr] : 16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            indirect_index <= `LIM_INDEX_RESET;
        end else if (wr_index) begin
            indirect_index <= wr_word;
        end
    end

    // Memory contents are not reset
    always_ff @(posedge hclk) begin
        if (wr_data && idx_in_range) begin
            indirect_mem[mem_addr] <= wr_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            factory_calibration <= `LIM_CAL_RESET;
        end else if (wr_cal) begin
            factory_calibration <= wr_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            module_config <= `LIM_CFG_RESET;
        end else if (wr_cfg) begin
            module_config <= wr_word & `LIM_CFG_WMASK;
        end
    end

    // Channel fault word, two bits per channel
    wire [2*NUM_CHAN-1:0] fault_word;
    wire [15:0] chan_value [NUM_CHAN];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            assign chan_value[ch] = chan_in[ch].value;
            if (ch == 0) begin : g_first
                assign fault_word[0] = chan_in[0].comm_fail;
                assign fault_word[1] = chan_in[0].range_fault
                                     | chan_in[0].fuse_blown
                                     | chan_in[0].open_loop;
            end else if (ch == 1) begin : g_second
                assign fault_word[2] = chan_in[1].comm_fail;
                assign fault_word[3] = chan_in[1].range_fault;
            end else begin : g_rest
                assign fault_word[2*ch] = chan_in[ch].ref_error;
                assign fault_word[2*ch+1] = chan_in[ch].range_fault;
            end
        end
    endgenerate

    // Module error state: forced by software or raised internally
    wire internal_error;
    wire error_state;
    wire point_fault;

    assign internal_error = diag_in.mem_error | diag_in.ref_err_a | diag_in.ref_err_b;
    assign error_state = module_config[`LIM_CFG_FORCE_ERR] | internal_error;
    assign point_fault = (|fault_word) | error_state | diag_in.field_power_fail;

    // Status word seen on reads of the configuration offset
    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[`LIM_CFG_CONFIGURED] = module_config[`LIM_CFG_CONFIGURED];
        status_word[`LIM_CFG_FORCE_ERR] = error_state;
        status_word[`LIM_CFG_MAINS_50HZ] = module_config[`LIM_CFG_MAINS_50HZ];
        status_word[`LIM_CFG_SELF_CAL] = module_config[`LIM_CFG_SELF_CAL];
        status_word[`LIM_CFG_DIAG] = module_config[`LIM_CFG_DIAG];
        status_word[`LIM_STS_MEM_ERR] = diag_in.mem_error;
        status_word[`LIM_STS_REF_A] = diag_in.ref_err_a;
        status_word[`LIM_STS_REF_B] = diag_in.ref_err_b;
        status_word[`LIM_STS_NOT_CAL] = diag_in.not_calibrated;
        status_word[`LIM_STS_FIELD_PWR] = diag_in.field_power_fail;
        status_word[`LIM_STS_POINT_FAULT] = point_fault;
    end

    // Read view of every register; write-only and unused words read zero
    wire [15:0] rd_word [`LIM_NUM_REGS];

    assign rd_word[`LIM_IDX_INDEX] = 16'h0000;
    assign rd_word[`LIM_IDX_DATA] = mem_rdata;

    genvar ri;
    generate
        for (ri = 0; ri < NUM_CHAN; ri++) begin : g_rd_chan
            assign rd_word[ri + 2] = chan_value[ri];
        end
    endgenerate

    assign rd_word[`LIM_IDX_CAL] = factory_calibration;
    assign rd_word[`LIM_IDX_FWREV] = FW_REVISION;
    assign rd_word[`LIM_IDX_FAULT] = fault_word;
    assign rd_word[`LIM_IDX_CFG] = status_word;
    assign rd_word[`LIM_IDX_COMM] = {field_dev_present, 8'h00};
    assign rd_word[`LIM_IDX_ID] = ELECTRONIC_ID;

    wire [15:0] rd_sel;
    assign rd_sel = addr_mapped ? rd_word[addr_idx] : 16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `LIM_RDATA_RESET;
        end else if (clk_en && dphase == LIM_DP_READ1) begin
            hrdata <= {16'h0000, rd_sel};
        end
    end

    // Control outputs are registered so the pins never see decode glitches;
    // they trail the configuration flops by one cycle.
    wire lim_ctrl_out_t next_ctrl;

    assign next_ctrl = {module_config[`LIM_CFG_CONFIGURED], error_state,
                        module_config[`LIM_CFG_MAINS_50HZ], module_config[`LIM_CFG_SELF_CAL],
                        module_config[`LIM_CFG_DIAG]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_out <= `LIM_CTRL_RESET;
        end else if (clk_en) begin
            ctrl_out <= next_ctrl;
        end
    end

endmodule

//--- sim/lim_regs_asserts.sv
`timescale 1ns/100ps
module lim_regs_asserts
    import lim_pkg::*;
#(
    parameter int NUM_CHAN = 8,
    parameter logic [15:0] ELECTRONIC_ID = 16'h5A5A
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire lim_chan_in_t chan_in [NUM_CHAN],
    input wire lim_diag_in_t diag_in,
    input wire logic [7:0] field_dev_present,
    input wire lim_ctrl_out_t ctrl_out
);
    wire take = hsel & htrans[1] & hready & clk_en & hreadyout;
    wire hit = take & (haddr[31:6] == 26'h0);
    wire rd_c = hit & !hwrite & (haddr[5:2] == 4'hC);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_wait: assert property (take && !hwrite ##1 clk_en |-> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_fault_ch1: assert property (rd_c ##1 clk_en |=> hrdata[1:0] ==
        $past({chan_in[0].range_fault | chan_in[0].fuse_blown | chan_in[0].open_loop,
        chan_in[0].comm_fail})) else $error("channel one flags wrong");
    a_fault_ch2: assert property (rd_c ##1 clk_en |=> hrdata[3:2] ==
        $past({chan_in[1].range_fault, chan_in[1].comm_fail})) else $error("channel two flags");
    a_fault_ch8: assert property (rd_c ##1 clk_en |=> hrdata[15:14] ==
        $past({chan_in[7].range_fault, chan_in[7].ref_error})) else $error("channel eight flags");
    a_cfg_applied: assert property (hit && hwrite && haddr[5:2] == 4'hD
        ##1 clk_en ##1 clk_en |=> ctrl_out.configured == $past(hwdata[0], 2)
        && ($past(hwdata[1], 2) -> ctrl_out.error_led)) else $error("config not applied");
    a_error_led: assert property ((diag_in.mem_error | diag_in.ref_err_a | diag_in.ref_err_b)
        && clk_en |=> ctrl_out.error_led) else $error("error indicator dark");
    a_id_read: assert property (hit && !hwrite && haddr[5:2] == 4'hF ##1 clk_en
        |=> hrdata == {16'h0000, ELECTRONIC_ID}) else $error("identity wrong");
endmodule

//--- sim/lim_field_model.sv
`timescale 1ns/100ps
module lim_field_model
    import lim_pkg::*;
(
    input wire logic [15:0] pat,
    input wire logic fuse,
    output lim_chan_in_t chan_in [8],
    output logic [7:0] field_dev_present
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            chan_in[i].value = {4'(i + 1), 12'h3C5};
            chan_in[i].comm_fail = (i < 2) ? pat[2 * i] : 1'b0;
            chan_in[i].ref_error = (i < 2) ? 1'b0 : pat[2 * i];
            chan_in[i].range_fault = pat[2 * i + 1];
            chan_in[i].fuse_blown = (i == 0) ? fuse : 1'b0;
            chan_in[i].open_loop = 1'b0;
        end
        field_dev_present = pat[15:8];
    end
endmodule

//--- sim/loop_input_module_register_map_bench.sv
`timescale 1ns/100ps
module loop_input_module_register_map_bench;
    import lim_pkg::*;
    logic hclk = 0, hresetn = 0, hwrite = 0, fuse = 0, clk_en = 1, hsel = 1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp;
    logic [15:0] pat = 16'h0;
    logic [7:0] present;
    lim_chan_in_t chan_in [8];
    lim_diag_in_t diag_in = '0;
    lim_ctrl_out_t ctrl_out;
    int fail_count = 0, checked = 0, cycles = 0;
    initial forever #20 hclk = ~hclk;
    lim_regs lim_regs_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .chan_in(chan_in), .diag_in(diag_in), .field_dev_present(present), .ctrl_out(ctrl_out));
    lim_field_model lim_field_model_inst (.pat(pat), .fuse(fuse), .chan_in(chan_in),
        .field_dev_present(present));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        xfer(1'b1, {26'h0, i, 2'h0}, d);
    endtask
    task automatic rd(input logic [3:0] i, input logic [31:0] e);
        xfer(1'b0, {26'h0, i, 2'h0}, 32'h0);
        check(r, e);
    endtask
    task automatic summarize();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(4'hD, 32'h0);
        rd(4'hA, 32'h0);
        rd(4'h0, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(4'(i + 2), 32'hFFFF);
            rd(4'(i + 2), {16'h0, 4'(i + 1), 12'h3C5});
        end
        $display("test channels done");
        for (int k = 0; k < 16; k++) begin
            pat <= 16'h1 << k;
            wr(4'hC, 32'hFFFF);
            rd(4'hC, 32'h1 << k);
        end
        rd(4'hE, 32'h8000);
        pat <= 16'h0;
        fuse <= 1'b1;
        rd(4'hC, 32'h2);
        fuse <= 1'b0;
        $display("test faults done");
        wr(4'hA, 32'hFFFF_A5C3);
        rd(4'hA, 32'hA5C3);
        clk_en <= 1'b0;
        wr(4'hA, 32'h1111);
        clk_en <= 1'b1;
        hsel <= 1'b0;
        wr(4'hA, 32'h2222);
        hsel <= 1'b1;
        rd(4'hA, 32'hA5C3);
        wr(4'hD, 32'hFFFF);
        repeat (2) @(posedge hclk);
        check({27'h0, ctrl_out}, 32'h1F);
        rd(4'hD, 32'h808F);
        wr(4'hD, 32'h0);
        diag_in <= 5'h10;
        rd(4'hD, 32'h8102);
        check({31'h0, ctrl_out.error_led}, 32'h1);
        diag_in <= 5'h00;
        repeat (2) @(posedge hclk);
        check({31'h0, ctrl_out.error_led}, 32'h0);
        $display("test config done");
        wr(4'h0, 32'h5);
        wr(4'h1, 32'h1234);
        wr(4'h0, 32'h6);
        wr(4'h1, 32'h4321);
        wr(4'h0, 32'h5);
        rd(4'h1, 32'h1234);
        wr(4'h0, 32'h012C);
        wr(4'h1, 32'hBEEF);
        rd(4'h1, 32'h0);
        $display("test indirect done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(4'hA, 32'h0);
        rd(4'h0, 32'h0);
        $display("test second reset done");
        wr(4'hF, 32'h0);
        rd(4'hF, 32'h5A5A);
        rd(4'hB, 32'h0001);
        xfer(1'b0, 32'h40, 32'h0);
        check(r, 32'h0);
        $display("test identity done");
        summarize();
    end
endmodule
bind lim_regs lim_regs_asserts #(.NUM_CHAN(NUM_CHAN), .ELECTRONIC_ID(ELECTRONIC_ID))
    lim_regs_asserts_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .chan_in(chan_in), .diag_in(diag_in), .field_dev_present(field_dev_present),
    .ctrl_out(ctrl_out));
